// file: src/rts_consts.vh
// constants for the reset and time-out sequencer
`ifndef RTS_CONSTS_VH
`define RTS_CONSTS_VH

// timing base and figures
`define RTS_CLK_PERIOD_NS 50
`define RTS_PIN_FILTER_NS 2000
`define RTS_PIN_FILTER_CYC ((`RTS_PIN_FILTER_NS + `RTS_CLK_PERIOD_NS - 1) / `RTS_CLK_PERIOD_NS)
`define RTS_BOD_MIN_NS 100000
`define RTS_BOD_MIN_CYC ((`RTS_BOD_MIN_NS + `RTS_CLK_PERIOD_NS - 1) / `RTS_CLK_PERIOD_NS)
`define RTS_PWRUP_DELAY_MS 72
`define RTS_RC_CLK_KHZ 100
`define RTS_PWRUP_DELAY_CYC (`RTS_PWRUP_DELAY_MS * `RTS_RC_CLK_KHZ)
`define RTS_OST_CYCLES 1024

// register byte offsets
`define RTS_OFS_CTRL 8'h00
`define RTS_OFS_STATUS 8'h04
`define RTS_OFS_CAUSE 8'h08
`define RTS_OFS_GENERAL 8'h0C
`define RTS_OFS_SCRATCH 8'h10

// control register fields
`define RTS_CTRL_PINSEL 0
`define RTS_CTRL_POWER_UP_DELAY_TIMER_DIS 1
`define RTS_CTRL_BOD_EN 2
`define RTS_CTRL_OSC_LSB 3
`define RTS_CTRL_OSC_MSB 5
`define RTS_CTRL_GPIO_OUT 6
`define RTS_CTRL_GPIO_OE 7
`define RTS_CTRL_RESET 8'h3F

// status register fields
`define RTS_ST_BOD_N 0
`define RTS_ST_POR_N 1
`define RTS_ST_TO 2
`define RTS_ST_PD 3
`define RTS_ST_WDCLR 4
`define RTS_ST_PIN 5

// oscillator mode codes
`define RTS_OSC_LP 3'h0
`define RTS_OSC_XT 3'h1
`define RTS_OSC_HS 3'h2
`define RTS_OSC_EC 3'h3

// last reset cause codes
`define RTS_CAUSE_NONE 3'h0
`define RTS_CAUSE_POR 3'h1
`define RTS_CAUSE_WDT_RUN 3'h2
`define RTS_CAUSE_WDT_SLEEP 3'h3
`define RTS_CAUSE_PIN_RUN 3'h4
`define RTS_CAUSE_PIN_SLEEP 3'h5
`define RTS_CAUSE_BOD 3'h6

`endif

// file: src/rts_edge_counter.v
// edge counter for a slow clock sampled on the system clock
`timescale 1ns/1ns
module rts_edge_counter #(
   parameter WIDTH = 16,
   parameter [WIDTH-1:0] TERMINAL = 16'h0400
) (
   // clock and reset
   input wire sys_clk,
   input wire reset,
   // sampled clock and control
   input wire clk_sample,
   input wire run,
   output wire done
);

   reg sync1_reg;
   reg sync2_reg;
   reg prev_reg;
   reg [WIDTH-1:0] cnt_reg;
   wire edge_seen;

   // two-flop synchroniser, edge taken from the second stage only
   always @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         sync1_reg <= 1'b0;
         sync2_reg <= 1'b0;
         prev_reg <= 1'b0;
      end else begin
         sync1_reg <= clk_sample;
         sync2_reg <= sync1_reg;
         prev_reg <= sync2_reg;
      end
   end

   assign edge_seen = sync2_reg & ~prev_reg;

   // counter clears whenever run drops so each run is a full interval
   always @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         cnt_reg <= {WIDTH{1'b0}};
      end else if (!run) begin
         cnt_reg <= {WIDTH{1'b0}};
      end else if (edge_seen && cnt_reg != TERMINAL) begin
         cnt_reg <= cnt_reg + {{(WIDTH-1){1'b0}}, 1'b1};
      end
   end

   assign done = run && (cnt_reg == TERMINAL);

endmodule // rts_edge_counter

// file: src/rts_reset_sequencer.v
// reset and time-out sequencer with apb status and configuration
`timescale 1ns/1ns
`include "rts_consts.vh"

// Summary of operation
// - six reset causes are recorded: power-on, watchdog run/sleep, pin run/sleep, brown-out
// - core reset clears ordinary state; watchdog wake-up leaves it untouched
// - scratch register is unknown at power-on and kept through other resets
// - reset pin is filtered so short low glitches cause no reset
// - watchdog reset stays internal and never drives the reset pin low
// - internal reset option treats pin reset as inactive; no pull-up provided
// - pin select 1 means reset input, 0 means digital input/output
// - power-on detector holds reset until supply good; no reset on fall
// - power-up delay of nominal 72 ms, only after power-on or brown-out
// - power-up delay disable bit set turns the delay off, clear enables
// - oscillator start-up holds a further 1024 crystal clock cycles
// - start-up count only in crystal modes, on power-on or wake from sleep
// - brown-out enable bit clear disables detection, set enables it
// - brown-out resets only after indication persists beyond minimum duration
// - after reset stay held until supply recovers, then optional delay
// - brown-out during the delay restarts a full delay after recovery
// - power-up runs delay then start-up count; total depends on settings
// - external clock with delay disabled gives no time-out at all
// - time-outs run regardless of pin; late pin release starts at once
// - power-on flag reads 0 after power-on, software writes 1 afterwards
// - brown-out flag cleared by brown-out reset, software sets it
module rts_reset_sequencer #(
   parameter PWRUP_DELAY_COUNT = `RTS_PWRUP_DELAY_CYC,
   parameter OST_COUNT = `RTS_OST_CYCLES
) (
   // clock and power-on reset
   input wire sys_clk,
   input wire reset,
   // apb slave
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [7:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output wire pready,
   output wire pslverr,
   // shared reset pin
   input wire ext_reset_pin_n_in,
   output wire ext_reset_pin_n_out,
   output wire ext_reset_pin_n_oe,
   // slow clocks sampled on sys_clk
   input wire rc_osc_clk,
   input wire osc1_clk,
   // supply and watchdog
   input wire brownout_detect,
   input wire watchdog_timeout,
   input wire core_sleep,
   // core side
   output reg core_reset,
   output reg core_wake,
   output reg gpio_in
);

   // sequencer states
   localparam [2:0] S_HOLD = 3'h0;
   localparam [2:0] S_POWER_UP_DELAY_TIMER = 3'h1;
   localparam [2:0] S_OST = 3'h2;
   localparam [2:0] S_RUN = 3'h3;
   localparam [2:0] S_WAKE_OST = 3'h4;

   // integer figures cut to the 16-bit counters on purpose
   localparam integer PIN_FILT_INT = `RTS_PIN_FILTER_CYC;
   localparam integer BOD_MIN_INT = `RTS_BOD_MIN_CYC;
   localparam integer POWER_UP_DELAY_TIMER_TERM_INT = PWRUP_DELAY_COUNT;
   localparam integer OST_TERM_INT = OST_COUNT;
   localparam [15:0] PIN_FILT = PIN_FILT_INT[15:0];
   localparam [15:0] BOD_MIN = BOD_MIN_INT[15:0];
   localparam [15:0] POWER_UP_DELAY_TIMER_TERM = POWER_UP_DELAY_TIMER_TERM_INT[15:0];
   localparam [15:0] OST_TERM = OST_TERM_INT[15:0];

   reg [2:0] state_reg;
   reg [2:0] state_next;
   reg [7:0] ctrl_reg;
   reg [15:0] pin_cnt_reg;
   reg pin_rst_reg;
   reg [15:0] bod_cnt_reg;
   reg por_pending_reg;
   reg wdt_rst_reg;
   reg sleep_prev_reg;
   reg por_flag_n_reg;
   reg bod_flag_n_reg;
   reg to_flag_reg;
   reg pd_flag_reg;
   reg [2:0] cause_reg;
   reg [31:0] general_reg;
   reg [31:0] scratch_reg;
   reg core_reset_next;
   wire power_up_delay_timer_done;
   wire ost_done;
   wire bod_en;
   wire power_up_delay_timer_dis;
   wire pin_sel;
   wire crystal_mode;
   wire bod_raw;
   wire bod_qual;
   wire pin_event;
   wire wdt_run;
   wire wdt_sleep;
   wire sleep_enter;
   wire wr_en;
   wire rd_setup;
   wire mapped;
   wire ost_start;

   assign pin_sel = ctrl_reg[`RTS_CTRL_PINSEL];
   assign power_up_delay_timer_dis = ctrl_reg[`RTS_CTRL_POWER_UP_DELAY_TIMER_DIS];
   assign bod_en = ctrl_reg[`RTS_CTRL_BOD_EN];
   // start-up count only for the three crystal modes
   assign crystal_mode =
      (ctrl_reg[`RTS_CTRL_OSC_MSB:`RTS_CTRL_OSC_LSB] == `RTS_OSC_LP) ||
      (ctrl_reg[`RTS_CTRL_OSC_MSB:`RTS_CTRL_OSC_LSB] == `RTS_OSC_XT) ||
      (ctrl_reg[`RTS_CTRL_OSC_MSB:`RTS_CTRL_OSC_LSB] == `RTS_OSC_HS);
   assign bod_raw = bod_en & brownout_detect;
   assign bod_qual = bod_en && (bod_cnt_reg == BOD_MIN);
   assign wdt_run = watchdog_timeout && !core_sleep && state_reg == S_RUN;
   assign wdt_sleep = watchdog_timeout && core_sleep && state_reg == S_RUN;
   assign sleep_enter = core_sleep && !sleep_prev_reg;
   assign pin_event = pin_rst_reg == 1'b0 && pin_sel &&
                      pin_cnt_reg == PIN_FILT - 16'h0001;
   assign ost_start = crystal_mode && por_pending_reg;

   // power-up delay counts rc clock edges through a synchroniser
   rts_edge_counter #(
      .WIDTH(16),
      .TERMINAL(POWER_UP_DELAY_TIMER_TERM)
   ) u_power_up_delay_timer (
      .sys_clk(sys_clk),
      .reset(reset),
      .clk_sample(rc_osc_clk),
      .run(state_reg == S_POWER_UP_DELAY_TIMER),
      .done(power_up_delay_timer_done)
   );

   // start-up count on the crystal input clock
   rts_edge_counter #(
      .WIDTH(16),
      .TERMINAL(OST_TERM)
   ) u_ost (
      .sys_clk(sys_clk),
      .reset(reset),
      .clk_sample(osc1_clk),
      .run(state_reg == S_OST || state_reg == S_WAKE_OST),
      .done(ost_done)
   );

   // reset pin glitch filter: must stay low for the full filter time
   always @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         pin_cnt_reg <= 16'h0000;
         pin_rst_reg <= 1'b0;
      end else if (!pin_sel || ext_reset_pin_n_in) begin
         pin_cnt_reg <= 16'h0000;
         pin_rst_reg <= 1'b0;
      end else if (pin_cnt_reg != PIN_FILT) begin
         pin_cnt_reg <= pin_cnt_reg + 16'h0001;
         pin_rst_reg <= (pin_cnt_reg == PIN_FILT - 16'h0001);
      end
   end

   // brown-out must persist for the minimum duration to qualify
   always @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         bod_cnt_reg <= 16'h0000;
      end else if (!bod_raw) begin
         bod_cnt_reg <= 16'h0000;
      end else if (bod_cnt_reg != BOD_MIN) begin
         bod_cnt_reg <= bod_cnt_reg + 16'h0001;
      end
   end

   // sequencer next state; reset port is the power-on detector output
   always @* begin
      state_next = state_reg;
      case (state_reg)
         S_HOLD: begin
            // held until supply is above release level
            if (!bod_raw) begin
               if (!power_up_delay_timer_dis) begin
                  state_next = S_POWER_UP_DELAY_TIMER;
               end else if (ost_start) begin
                  state_next = S_OST;
               end else begin
                  state_next = S_RUN;
               end
            end
         end
         S_POWER_UP_DELAY_TIMER: begin
            if (bod_raw) begin
               state_next = S_HOLD;
            end else if (power_up_delay_timer_done) begin
               state_next = ost_start ? S_OST : S_RUN;
            end
         end
         S_OST: begin
            if (bod_qual) begin
               state_next = S_HOLD;
            end else if (ost_done) begin
               state_next = S_RUN;
            end
         end
         S_RUN: begin
            if (bod_qual) begin
               state_next = S_HOLD;
            end else if (wdt_sleep && crystal_mode) begin
               state_next = S_WAKE_OST;
            end
         end
         S_WAKE_OST: begin
            if (bod_qual) begin
               state_next = S_HOLD;
            end else if (ost_done) begin
               state_next = S_RUN;
            end
         end
         default: begin
            state_next = S_HOLD;
         end
      endcase
   end

   // sequencer state and power-on bookkeeping
   always @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         state_reg <= S_HOLD;
         por_pending_reg <= 1'b1;
         wdt_rst_reg <= 1'b0;
         sleep_prev_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         // brown-out entry skips the start-up count
         if (state_next == S_RUN) begin
            por_pending_reg <= 1'b0;
         end
         wdt_rst_reg <= wdt_run;
         sleep_prev_reg <= core_sleep;
      end
   end

   // core reset is the or of every source, registered on sys_clk
   always @* begin
      core_reset_next = (state_next != S_RUN &&
                         state_next != S_WAKE_OST) ||
                        pin_rst_reg || pin_event || wdt_run;
   end

   // wake pulse after a watchdog wake, with start-up count when needed
   always @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         core_reset <= 1'b1;
         core_wake <= 1'b0;
      end else begin
         core_reset <= core_reset_next;
         core_wake <= (wdt_sleep && !crystal_mode && !bod_qual) ||
                      (state_reg == S_WAKE_OST && ost_done &&
                       !bod_qual);
      end
   end

   // cause flags; hardware events take priority over software writes
   always @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         por_flag_n_reg <= 1'b0;
         bod_flag_n_reg <= 1'b0;
         to_flag_reg <= 1'b1;
         pd_flag_reg <= 1'b1;
         cause_reg <= `RTS_CAUSE_POR;
      end else begin
         if (state_reg != S_HOLD && state_next == S_HOLD) begin
            bod_flag_n_reg <= 1'b0;
            to_flag_reg <= 1'b1;
            pd_flag_reg <= 1'b1;
            cause_reg <= `RTS_CAUSE_BOD;
         end else if (wdt_run) begin
            to_flag_reg <= 1'b0;
            cause_reg <= `RTS_CAUSE_WDT_RUN;
         end else if (wdt_sleep) begin
            to_flag_reg <= 1'b0;
            pd_flag_reg <= 1'b0;
            cause_reg <= `RTS_CAUSE_WDT_SLEEP;
         end else if (pin_event) begin
            if (core_sleep) begin
               to_flag_reg <= 1'b1;
               pd_flag_reg <= 1'b0;
               cause_reg <= `RTS_CAUSE_PIN_SLEEP;
            end else begin
               cause_reg <= `RTS_CAUSE_PIN_RUN;
            end
         end else if (sleep_enter) begin
            to_flag_reg <= 1'b1;
            pd_flag_reg <= 1'b0;
         end else if (wr_en && paddr == `RTS_OFS_STATUS) begin
            if (pwdata[`RTS_ST_BOD_N]) begin
               bod_flag_n_reg <= 1'b1;
            end
            if (pwdata[`RTS_ST_WDCLR]) begin
               to_flag_reg <= 1'b1;
               pd_flag_reg <= 1'b1;
            end
         end
         // power-on flag only ever changes by software write of one
         if (wr_en && paddr == `RTS_OFS_STATUS &&
             pwdata[`RTS_ST_POR_N]) begin
            por_flag_n_reg <= 1'b1;
         end
      end
   end

   // apb handshake: zero wait states, error on unmapped word
   assign wr_en = psel && penable && pwrite && mapped;
   assign rd_setup = psel && !penable && !pwrite;
   assign mapped = paddr == `RTS_OFS_CTRL || paddr == `RTS_OFS_STATUS ||
                   paddr == `RTS_OFS_CAUSE || paddr == `RTS_OFS_GENERAL ||
                   paddr == `RTS_OFS_SCRATCH;
   assign pready = 1'b1;
   assign pslverr = psel && penable && !mapped;

   // configuration, kept across every reset except power-on
   always @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         ctrl_reg <= `RTS_CTRL_RESET;
      end else if (wr_en && paddr == `RTS_OFS_CTRL) begin
         ctrl_reg <= pwdata[7:0];
      end
   end

   // ordinary state: cleared by core reset, not by a wake
   always @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         general_reg <= 32'h00000000;
      end else if (core_reset) begin
         general_reg <= 32'h00000000;
      end else if (wr_en && paddr == `RTS_OFS_GENERAL) begin
         general_reg <= pwdata;
      end
   end

   // retained state has no reset at all, so power-on leaves it unknown
   always @(posedge sys_clk) begin
      if (wr_en && paddr == `RTS_OFS_SCRATCH) begin
         scratch_reg <= pwdata;
      end
   end

   // read data latched in the setup phase, stable in the access phase
   always @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         prdata <= 32'h00000000;
      end else if (rd_setup) begin
         case (paddr)
            `RTS_OFS_CTRL: begin
               prdata <= {24'h000000, ctrl_reg};
            end
            `RTS_OFS_STATUS: begin
               prdata <= {26'h0000000, ext_reset_pin_n_in, 1'b0,
                          pd_flag_reg, to_flag_reg, por_flag_n_reg,
                          bod_flag_n_reg};
            end
            `RTS_OFS_CAUSE: begin
               prdata <= {25'h0000000, state_reg, 1'b0, cause_reg};
            end
            `RTS_OFS_GENERAL: begin
               prdata <= general_reg;
            end
            `RTS_OFS_SCRATCH: begin
               prdata <= scratch_reg;
            end
            default: begin
               prdata <= 32'h00000000;
            end
         endcase
      end
   end

   // pin is never driven in reset mode, so a watchdog reset stays inside
   assign ext_reset_pin_n_oe = !pin_sel &&
                               ctrl_reg[`RTS_CTRL_GPIO_OE];
   assign ext_reset_pin_n_out = ctrl_reg[`RTS_CTRL_GPIO_OUT];

   // digital input view of the pin in i/o mode
   always @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         gpio_in <= 1'b0;
      end else begin
         gpio_in <= !pin_sel && ext_reset_pin_n_in;
      end
   end

endmodule // rts_reset_sequencer

// file: sim/rts_far_side.sv
// far-side model: board reset pin driver, supply monitor, slow clocks
`timescale 1ns/1ns
module rts_far_side (
   // system clock
   input wire sys_clk,
   // scenario control from the bench
   input wire pin_drive_n,
   input wire supply_low,
   // device drive of the shared pin
   input wire pin_out,
   input wire pin_oe,
   // towards the device
   output wire pin_level,
   output reg brownout_detect = 1'b0,
   output wire rc_osc_clk,
   output wire osc1_clk
);
   reg [2:0] div_reg = 3'h0;
   // device drive wins; no pull-up, so the board always drives the rest
   assign pin_level = pin_oe ? pin_out : pin_drive_n;
   // rc at 1/8 and crystal at 1/4 of sys_clk, levels of 2 cycles or more
   assign rc_osc_clk = div_reg[2];
   assign osc1_clk = div_reg[1];
   // monitor reports the supply one cycle late, like a comparator
   always @(posedge sys_clk) begin
      div_reg <= div_reg + 3'h1;
      brownout_detect <= supply_low;
   end
endmodule // rts_far_side

// file: sim/rts_reset_sequencer_properties.sv
// port assertions for the reset sequencer
`timescale 1ns/1ns
module rts_reset_sequencer_properties (
   // clock and reset
   input wire sys_clk,
   input wire reset,
   // bus request
   input wire psel,
   input wire penable,
   input wire pwrite,
   // pin, supply and watchdog
   input wire ext_reset_pin_n_in,
   input wire ext_reset_pin_n_oe,
   input wire brownout_detect,
   input wire watchdog_timeout,
   input wire core_sleep,
   // core side
   input wire core_reset,
   input wire core_wake,
   input wire gpio_in
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (reset);
   // no pin or supply cause pending, so only the named cause may act
   wire quiet = ext_reset_pin_n_in && !brownout_detect;

   chk_release_time: assert property (
      $fell(reset) && quiet |-> ##[1:3] !core_reset)
      else $error("core reset not released after power-on");
   chk_wdt_width: assert property (
      watchdog_timeout && quiet && !core_sleep && !core_reset
      |=> core_reset ##1 !core_reset)
      else $error("watchdog reset not one cycle wide");
   chk_wdt_no_drive: assert property (
      watchdog_timeout && !ext_reset_pin_n_oe && !(psel && penable && pwrite)
      |=> !ext_reset_pin_n_oe)
      else $error("watchdog reset drove the pin");
   chk_pin_glitch: assert property (
      !core_reset && ext_reset_pin_n_in ##1 (!ext_reset_pin_n_in &&
      !brownout_detect && !watchdog_timeout && !psel)[*8] |-> !core_reset)
      else $error("short pin pulse caused a reset");
   chk_bod_short: assert property (
      !core_reset && !brownout_detect ##1 (brownout_detect &&
      ext_reset_pin_n_in && !watchdog_timeout && !psel)[*8] |-> !core_reset)
      else $error("short brown-out caused a reset");
   chk_sleep_no_reset: assert property (
      core_sleep && quiet && !core_reset |=> !core_reset)
      else $error("reset raised during sleep wake-up");
   chk_wake_pulse: assert property (
      core_wake |-> !core_reset ##1 !core_wake)
      else $error("wake pulse malformed");
   chk_gpio_level: assert property (
      gpio_in |-> $past(ext_reset_pin_n_in))
      else $error("pin input level wrong");
   chk_pin_ignored: assert property (
      ext_reset_pin_n_oe && !core_reset && !brownout_detect &&
      !watchdog_timeout |=> !core_reset)
      else $error("pin acted as reset while in io use");
endmodule // rts_reset_sequencer_properties

bind rts_reset_sequencer rts_reset_sequencer_properties chk (
   .sys_clk(sys_clk), .reset(reset), .psel(psel), .penable(penable),
   .pwrite(pwrite), .ext_reset_pin_n_in(ext_reset_pin_n_in),
   .ext_reset_pin_n_oe(ext_reset_pin_n_oe),
   .brownout_detect(brownout_detect), .watchdog_timeout(watchdog_timeout),
   .core_sleep(core_sleep), .core_reset(core_reset),
   .core_wake(core_wake), .gpio_in(gpio_in));

// file: sim/rts_reset_sequencer_tb_top.sv
// self-checking bench for the reset sequencer
`timescale 1ns/1ns
module rts_reset_sequencer_tb_top;
   reg sys_clk = 1'b0;
   reg reset = 1'b1;
   reg psel = 1'b0;
   reg penable = 1'b0;
   reg pwrite = 1'b0;
   reg [7:0] paddr = 8'h00;
   reg [31:0] pwdata = 32'h0;
   reg pin_drive_n = 1'b1;
   reg supply_low = 1'b0;
   reg watchdog_timeout = 1'b0;
   reg core_sleep = 1'b0;
   wire [31:0] prdata;
   wire pready;
   wire pslverr;
   wire pin_level;
   wire pin_out;
   wire pin_oe;
   wire brownout_detect;
   wire rc_osc_clk;
   wire osc1_clk;
   wire core_reset;
   wire core_wake;
   wire gpio_in;
   reg [31:0] rd;
   reg er;
   integer n;
   integer mismatches = 0;
   integer samples_checked = 0;

   // 20 MHz system clock
   always #25 sys_clk = ~sys_clk;

   // short counts keep the run brief
   rts_reset_sequencer #(.PWRUP_DELAY_COUNT(8), .OST_COUNT(4)) uut (
      .sys_clk(sys_clk), .reset(reset), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .ext_reset_pin_n_in(pin_level),
      .ext_reset_pin_n_out(pin_out), .ext_reset_pin_n_oe(pin_oe),
      .rc_osc_clk(rc_osc_clk), .osc1_clk(osc1_clk),
      .brownout_detect(brownout_detect),
      .watchdog_timeout(watchdog_timeout), .core_sleep(core_sleep),
      .core_reset(core_reset), .core_wake(core_wake), .gpio_in(gpio_in));

   rts_far_side far (
      .sys_clk(sys_clk), .pin_drive_n(pin_drive_n), .supply_low(supply_low),
      .pin_out(pin_out), .pin_oe(pin_oe), .pin_level(pin_level),
      .brownout_detect(brownout_detect), .rc_osc_clk(rc_osc_clk),
      .osc1_clk(osc1_clk));

   task results;
      begin
         $display("checks %0d mismatches %0d", samples_checked, mismatches);
         if (mismatches == 0 && samples_checked > 0)
            $display("Finished cleanly");
         else
            $display("Finished with errors");
         $finish;
      end
   endtask

   task check(input [31:0] got, input [31:0] exp);
      begin
         samples_checked = samples_checked + 1;
         if (got !== exp) begin
            mismatches = mismatches + 1;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
         end
      end
   endtask

   // one apb transfer; request held until pready is seen high
   task apb(input wr, input [7:0] a, input [31:0] d);
      integer k;
      begin
         psel <= 1'b1;
         pwrite <= wr;
         paddr <= a;
         pwdata <= d;
         @(posedge sys_clk);
         penable <= 1'b1;
         k = 0;
         @(posedge sys_clk);
         while (pready !== 1'b1 && k < 9) begin
            @(posedge sys_clk);
            k = k + 1;
         end
         if (pready !== 1'b1) begin
            check({31'h0, pready}, 32'h1);
            results;
         end
         rd = prdata;
         er = pslverr;
         psel <= 1'b0;
         penable <= 1'b0;
         @(posedge sys_clk);
      end
   endtask

   task rd_chk(input [7:0] a, input [31:0] m, input [31:0] e);
      begin
         apb(1'b0, a, 32'h0);
         check(rd & m, e);
      end
   endtask

   // bounded wait for core reset (sel 0) or wake pulse (sel 1)
   task wait_sig(input sel, input v, input integer lim);
      begin
         n = 0;
         while ((sel ? core_wake : core_reset) !== v && n < lim) begin
            @(posedge sys_clk);
            n = n + 1;
         end
         if ((sel ? core_wake : core_reset) !== v) begin
            check({31'h0, ~v}, {31'h0, v});
            results;
         end
      end
   endtask

   task wdt;
      begin
         watchdog_timeout <= 1'b1;
         @(posedge sys_clk);
         watchdog_timeout <= 1'b0;
      end
   endtask

   // main sequence
   initial begin
      repeat (8) @(posedge sys_clk);
      reset <= 1'b0;
      @(posedge sys_clk);
      wait_sig(1'b0, 1'b0, 10);
      rd_chk(8'h00, 32'hFF, 32'h3F);
      rd_chk(8'h04, 32'h2F, 32'h2C);
      rd_chk(8'h08, 32'h77, 32'h31);
      apb(1'b0, 8'h14, 32'h0);
      check({rd[30:0], er}, 32'h1);
      apb(1'b1, 8'h04, 32'h3);
      apb(1'b1, 8'h10, 32'h5A);
      $display("test defaults done");
      pin_drive_n <= 1'b0;
      repeat (20) @(posedge sys_clk);
      pin_drive_n <= 1'b1;
      @(posedge sys_clk);
      check({31'h0, core_reset}, 32'h0);
      apb(1'b1, 8'h0C, 32'hA5);
      pin_drive_n <= 1'b0;
      wait_sig(1'b0, 1'b1, 60);
      check({31'h0, n >= 39}, 32'h1);
      repeat (10) @(posedge sys_clk);
      pin_drive_n <= 1'b1;
      @(posedge sys_clk);
      wait_sig(1'b0, 1'b0, 4);
      rd_chk(8'h08, 32'h7, 32'h4);
      rd_chk(8'h0C, 32'hFF, 32'h0);
      rd_chk(8'h10, 32'hFF, 32'h5A);
      rd_chk(8'h04, 32'h3, 32'h3);
      $display("test pin done");
      apb(1'b1, 8'h0C, 32'hA5);
      wdt;
      wait_sig(1'b0, 1'b1, 3);
      wait_sig(1'b0, 1'b0, 3);
      check({31'h0, pin_oe}, 32'h0);
      rd_chk(8'h04, 32'h4, 32'h0);
      rd_chk(8'h08, 32'h7, 32'h2);
      rd_chk(8'h0C, 32'hFF, 32'h0);
      apb(1'b1, 8'h0C, 32'h33);
      core_sleep <= 1'b1;
      @(posedge sys_clk);
      wdt;
      wait_sig(1'b1, 1'b1, 4);
      core_sleep <= 1'b0;
      rd_chk(8'h04, 32'hC, 32'h0);
      rd_chk(8'h08, 32'h7, 32'h3);
      rd_chk(8'h0C, 32'hFF, 32'h33);
      apb(1'b1, 8'h00, 32'h0F);
      core_sleep <= 1'b1;
      @(posedge sys_clk);
      wdt;
      wait_sig(1'b1, 1'b1, 40);
      check({31'h0, n >= 12}, 32'h1);
      core_sleep <= 1'b0;
      apb(1'b1, 8'h00, 32'h3F);
      core_sleep <= 1'b1;
      pin_drive_n <= 1'b0;
      wait_sig(1'b0, 1'b1, 60);
      core_sleep <= 1'b0;
      pin_drive_n <= 1'b1;
      wait_sig(1'b0, 1'b0, 10);
      rd_chk(8'h04, 32'hC, 32'h4);
      rd_chk(8'h08, 32'h7, 32'h5);
      $display("test watchdog and sleep done");
      apb(1'b1, 8'h00, 32'h3D);
      supply_low <= 1'b1;
      wait_sig(1'b0, 1'b1, 2100);
      check({31'h0, n >= 1990}, 32'h1);
      supply_low <= 1'b0;
      repeat (20) @(posedge sys_clk);
      check({31'h0, core_reset}, 32'h1);
      supply_low <= 1'b1;
      repeat (4) @(posedge sys_clk);
      supply_low <= 1'b0;
      wait_sig(1'b0, 1'b0, 200);
      check({31'h0, n >= 50}, 32'h1);
      rd_chk(8'h04, 32'h3, 32'h2);
      rd_chk(8'h08, 32'h7, 32'h6);
      apb(1'b1, 8'h00, 32'h39);
      supply_low <= 1'b1;
      repeat (2100) @(posedge sys_clk);
      supply_low <= 1'b0;
      check({31'h0, core_reset}, 32'h0);
      $display("test brownout done");
      apb(1'b1, 8'h00, 32'hB8);
      repeat (60) @(posedge sys_clk);
      check({30'h0, pin_oe, pin_level}, 32'h2);
      check({30'h0, core_reset, gpio_in}, 32'h0);
      apb(1'b1, 8'h00, 32'h38);
      pin_drive_n <= 1'b0;
      repeat (60) @(posedge sys_clk);
      check({30'h0, core_reset, gpio_in}, 32'h0);
      pin_drive_n <= 1'b1;
      repeat (3) @(posedge sys_clk);
      check({31'h0, gpio_in}, 32'h1);
      $display("test pin select done");
      results;
   end
endmodule // rts_reset_sequencer_tb_top
